/* File: verilog/prc_soft_reset_ctrl.sv */
/*
 * prc_soft_reset_ctrl: software reset control for the I/O ports, the
 * synchronous serial unit and three asynchronous serial units, reached over
 * AXI4-Lite.
 * Assumes a single clock, synchronous reset, and that the capability input
 * is static or slow and synchronous to clk_sys.
 */
`timescale 1ns/10ps
module prc_soft_reset_ctrl (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               reset,
   // axi4-lite write address
   input  wire logic [11:0]        awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   // axi4-lite write data
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   // axi4-lite write response
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // axi4-lite read address
   input  wire logic [11:0]        araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   // axi4-lite read data
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // presence of each port unit
   input  wire logic [7:0]         capFour,
   // resets toward the peripherals
   output prc_pkg::prc_reset_t     resetOut
);

   // ****************************************
   // declarations
   // ****************************************
   logic        awHeld_r;
   logic        wHeld_r;
   logic [11:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic [7:0]  capFour_r;
   logic [31:0] portReg;
   logic [31:0] periphReg;

   wire         awTake;
   wire         wTake;
   wire         arTake;
   wire         wrFire;
   wire         awHeld_nxt;
   wire         wHeld_nxt;
   wire         bvalid_nxt;
   wire         rvalid_nxt;
   wire         wrHitPort;
   wire         wrHitPeriph;
   wire         wrHitCaps;
   wire         wrHit;
   wire         rdHitPort;
   wire         rdHitPeriph;
   wire         rdHitCaps;
   wire         rdHit;
   wire [31:0]  rdMux;
   wire [31:0]  portGate;

   // ****************************************
   // write channels
   // ****************************************

   // handshakes and the single write commit
   assign awTake     = awvalid & awready;
   assign wTake      = wvalid & wready;
   assign wrFire     = awHeld_r & wHeld_r & ~bvalid;
   assign awHeld_nxt = (awHeld_r | awTake) & ~wrFire;
   assign wHeld_nxt  = (wHeld_r | wTake) & ~wrFire;
   assign bvalid_nxt = wrFire | (bvalid & ~bready);

   // write address decode on the held address
   assign wrHitPort   = awAddr_r[11:2] == prc_pkg::PORT_RST_OFS[11:2]; // R1
   assign wrHitPeriph = awAddr_r[11:2] == prc_pkg::PERIPH_RST_OFS[11:2];
   assign wrHitCaps   = awAddr_r[11:2] == prc_pkg::CAPS_FOUR_OFS[11:2];
   assign wrHit       = wrHitPort | wrHitPeriph | wrHitCaps;

   // hold address and data until both have arrived
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= 12'h000;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
      end else begin
         awHeld_r <= awHeld_nxt;
         wHeld_r  <= wHeld_nxt;
         if (awTake) begin
            awAddr_r <= awaddr;
         end
         if (wTake) begin
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
      end
   end

   // ready and response flops
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= prc_pkg::RESP_OKAY;
      end else begin
         awready <= ~awHeld_nxt & ~bvalid_nxt;
         wready  <= ~wHeld_nxt & ~bvalid_nxt;
         bvalid  <= bvalid_nxt;
         if (wrFire) begin
            bresp <= wrHit ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************

   // capabilities snapshot, also the gate for port writes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         capFour_r <= prc_pkg::CAPS_FOUR_RESET;
      end else begin
         capFour_r <= capFour;
      end
   end

   assign portGate = {24'h00_0000, capFour_r}; // R2

   // port reset register, writes leave bits of absent units unchanged
   prc_masked_reg #(
      .WRITE_MASK (prc_pkg::PORT_RST_MASK),  // R4
      .RESET_VAL  (prc_pkg::PORT_RST_RESET)  // R1
   ) u_port_reg (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wrEn    (wrFire & wrHitPort),
      .wrData  (wData_r),
      .wrStrb  (wStrb_r),
      .gate    (portGate),
      .value   (portReg)
   );

   // low peripheral reset register, reserved bits fixed at zero
   prc_masked_reg #(
      .WRITE_MASK (prc_pkg::PERIPH_RST_MASK),  // R4
      .RESET_VAL  (prc_pkg::PERIPH_RST_RESET)  // R6 R7
   ) u_periph_reg (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wrEn    (wrFire & wrHitPeriph),
      .wrData  (wData_r),
      .wrStrb  (wStrb_r),
      .gate    (32'hFFFF_FFFF),
      .value   (periphReg)
   );

   // ****************************************
   // read channel
   // ****************************************

   // read decode and data select
   assign arTake      = arvalid & arready;
   assign rvalid_nxt  = arTake | (rvalid & ~rready);
   assign rdHitPort   = araddr[11:2] == prc_pkg::PORT_RST_OFS[11:2];
   assign rdHitPeriph = araddr[11:2] == prc_pkg::PERIPH_RST_OFS[11:2];
   assign rdHitCaps   = araddr[11:2] == prc_pkg::CAPS_FOUR_OFS[11:2];
   assign rdHit       = rdHitPort | rdHitPeriph | rdHitCaps;
   assign rdMux       = ({32{rdHitPort}} & portReg)
                      | ({32{rdHitPeriph}} & periphReg)
                      | ({32{rdHitCaps}} & {24'h00_0000, capFour_r});

   // one read in flight; data captured at the address handshake
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= prc_pkg::RESP_OKAY;
      end else begin
         arready <= ~rvalid_nxt;
         rvalid  <= rvalid_nxt;
         if (arTake) begin
            rdata <= rdMux;
            rresp <= rdHit ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // reset lines
   // ****************************************

   // a set bit holds its unit in reset, clear releases it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         resetOut <= '0;
      end else begin
         resetOut.portReset           <= portReg[prc_pkg::PORT_W-1:0]; // R3 R8
         resetOut.syncSerialZeroReset <= periphReg[prc_pkg::SYNC_SERIAL_BIT]; // R6 R8
         resetOut.asyncSerialReset    <=
            periphReg[prc_pkg::ASYNC_SERIAL_LSB +: prc_pkg::ASYNC_SERIAL_W]; // R7 R8
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // cleared on leaving reset
   chk_port_reset_clear: assert property ( // R1
      $past(reset) |-> (portReg == 32'h0000_0000 && periphReg == 32'h0000_0000))
      else $error("control register not clear after reset");

   // absent units cannot be set
   chk_absent_unit_gate: assert property ( // R2
      wrFire && wrHitPort |=> ((portReg & ~{24'h00_0000, $past(capFour_r)})
                               == ($past(portReg) & ~{24'h00_0000, $past(capFour_r)})))
      else $error("write changed bit of absent unit");

   // present port bits take the written value
   chk_port_write_lands: assert property ( // R3
      wrFire && wrHitPort && wStrb_r[0]
      |=> (portReg[7:0] & $past(capFour_r)) == $past(wData_r[7:0] & capFour_r))
      else $error("port reset write not stored");

   // reserved bits always read zero
   chk_reserved_read_zero: assert property ( // R4
      rvalid && rresp == prc_pkg::RESP_OKAY
      |-> (portReg & ~prc_pkg::PORT_RST_MASK) == 32'h0000_0000
          && (periphReg & ~prc_pkg::PERIPH_RST_MASK) == 32'h0000_0000)
      else $error("reserved bit not zero");

   // sync serial bit follows the write
   chk_sync_serial_write: assert property ( // R6
      wrFire && wrHitPeriph && wStrb_r[0]
      |=> periphReg[4] == $past(wData_r[4]) ##1 resetOut.syncSerialZeroReset == $past(periphReg[4]))
      else $error("sync serial reset not written");

   // async serial bits follow the write
   chk_async_serial_write: assert property ( // R7
      wrFire && wrHitPeriph && wStrb_r[0]
      |=> periphReg[2:0] == $past(wData_r[2:0]))
      else $error("async serial reset not written");

   // port and async serial reset lines track the registers one cycle later
   chk_reset_line_follow: assert property ( // R8
      !$past(reset) |-> resetOut.portReset == $past(portReg[7:0])
                        && resetOut.asyncSerialReset == $past(periphReg[2:0]))
      else $error("reset line does not follow register");

   // write answered one cycle after both parts held
   chk_write_response_time: assert property (
      wrFire |=> bvalid ##0 (bresp == prc_pkg::RESP_SLVERR) == !$past(wrHit))
      else $error("write response late or wrong");

   // no new write accepted while a response waits
   chk_write_refused: assert property (
      bvalid |-> !awready && !wready)
      else $error("write channel ready while response pending");

   // no new read accepted while read data waits
   chk_read_refused: assert property (
      rvalid |-> !arready)
      else $error("read address ready while data pending");

   // bits 31:8 of every read return zero
   chk_upper_read_zero: assert property ( // R4
      rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("reserved upper bits read nonzero");

   // gaps of the low register read zero
   chk_periph_gap_zero: assert property ( // R4
      arTake && rdHitPeriph |=> rdata[7:5] == 3'h0 && !rdata[3])
      else $error("reserved low register bit read nonzero");

   // port register read returns the stored value
   chk_port_read_value: assert property ( // R3
      arTake && rdHitPort |=> rdata == $past(portReg))
      else $error("port register read wrong");

   // sync serial line tracks its bit one cycle later
   chk_sync_line_follow: assert property ( // R8
      !$past(reset) |-> resetOut.syncSerialZeroReset == $past(periphReg[prc_pkg::SYNC_SERIAL_BIT]))
      else $error("sync serial reset line does not follow register");

   cov_port_write:   cover property (wrFire && wrHitPort);
   cov_absent_write: cover property (wrFire && wrHitPort && wStrb_r[0] && (wData_r[7:0] & ~capFour_r) != 8'h00);
   cov_periph_write: cover property (wrFire && wrHitPeriph);
   cov_read_back:    cover property (arTake && rdHitPort ##1 rvalid);
   cov_unmapped:     cover property (wrFire && !wrHit);

endmodule

/* File: verilog/prc_pkg.sv */
/*
 * prc_pkg: constants and types for the peripheral soft reset control block.
 * Assumes a 50 MHz system clock, a synchronous active-high reset and an
 * AXI4-Lite master with 12-bit byte addresses and 32-bit data.
 */
// Summary of operation
// (R1) port reset register at 0x048, resets to zero
// (R2) port register writes gated by capabilities four
// (R3) bits 7:0 drive port A..H resets
// (R4) reserved bits read zero, ignore writes
// (R5) software preserves reserved bits on read-modify-write
// (R6) low register bit 4 resets sync serial zero
// (R7) low register bits 2:0 reset async serial 2..0
// (R8) bit high holds peripheral in reset
package prc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] CAPS_FOUR_OFS   = 12'h01C;   // read-only capabilities
   localparam logic [11:0] PERIPH_RST_OFS  = 12'h044;
   localparam logic [11:0] PORT_RST_OFS    = 12'h048;

   // ****************************************
   // reset values and writable fields
   // ****************************************
   localparam logic [31:0] PERIPH_RST_RESET = 32'h0000_0000;
   localparam logic [31:0] PORT_RST_RESET   = 32'h0000_0000;
   localparam logic [31:0] PERIPH_RST_MASK  = 32'h0000_0017;  // bits 4, 2:0
   localparam logic [31:0] PORT_RST_MASK    = 32'h0000_00FF;  // bits 7:0
   localparam logic [7:0]  CAPS_FOUR_RESET  = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int PORT_W          = 8;
   localparam int SYNC_SERIAL_BIT = 4;
   localparam int ASYNC_SERIAL_LSB = 0;
   localparam int ASYNC_SERIAL_W  = 3;

   // ****************************************
   // bus answers
   // ****************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // reset lines toward the peripherals
   typedef struct packed {
      logic [7:0] portReset;            // bit 0 port A .. bit 7 port H
      logic       syncSerialZeroReset;
      logic [2:0] asyncSerialReset;     // bit n async serial unit n
   } prc_reset_t;

endpackage

/* File: verilog/prc_masked_reg.sv */
/*
 * prc_masked_reg: one 32-bit control register with byte strobes, a fixed
 * mask of writable bits and a run-time gate of writable bits.
 * Assumes write enable is a one-cycle pulse from the bus slave.
 */
`timescale 1ns/10ps
module prc_masked_reg #(
   parameter logic [31:0] WRITE_MASK = 32'hFFFF_FFFF,
   parameter logic [31:0] RESET_VAL  = 32'h0000_0000
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // write side
   input  wire logic        wrEn,
   input  wire logic [31:0] wrData,
   input  wire logic [3:0]  wrStrb,
   input  wire logic [31:0] gate,
   // stored value
   output logic      [31:0] value
);

   logic [31:0] strbMask;
   logic [31:0] wrMask;
   logic [31:0] value_nxt;

   // expand byte strobes to bit lanes
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : g_lane
         assign strbMask[lane*8 +: 8] = {8{wrStrb[lane]}};
      end
   endgenerate

   // only writable, present and strobed bits change
   assign wrMask    = WRITE_MASK & gate & strbMask;
   assign value_nxt = (value & ~wrMask) | (wrData & wrMask);

   // storage; bits outside the mask keep the reset value
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         value <= RESET_VAL;
      end else if (wrEn) begin
         value <= value_nxt;
      end
   end

endmodule

/* File: tb/tb.sv */
/*
 * tb: self-checking bench for prc_soft_reset_ctrl, driving AXI4-Lite and
 * the capability input with seeded random values and corner cases.
 * Assumes the package prc_pkg and the design are compiled before this file.
 */
`timescale 1ns/10ps
module tb;
   // ****************************************
   // signals
   // ****************************************
   logic                clk_sys, reset;
   logic [11:0]         awaddr, araddr;
   logic                awvalid, awready, wvalid, wready, bvalid, bready;
   logic                arvalid, arready, rvalid, rready;
   logic [31:0]         wdata, rdata;
   logic [3:0]          wstrb;
   logic [1:0]          bresp, rresp;
   logic [7:0]          capFour;
   prc_pkg::prc_reset_t resetOut;
   logic [31:0]         seed = 32'h3FEDDBBA;
   logic [31:0]         portExp, perExp;
   logic [11:0]         addrTab [4];
   int                  errCount, checks, cycles;
   logic [31:0]         rndA, rndD, rndS, rmwVal;
   logic [1:0]          rmwResp;

   prc_soft_reset_ctrl i_dut (.clk_sys(clk_sys), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .capFour(capFour),
      .resetOut(resetOut));

   // clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errCount++;
         summarize();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ****************************************
   // bus master
   // ****************************************
   task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
      logic aDone, wDone, got;
      aDone = 1'b0;
      wDone = 1'b0;
      got   = 1'b0;
      awaddr <= a;
      wdata  <= d;
      wstrb  <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got) begin
         @(posedge clk_sys);
         if (aDone && wDone && bvalid === 1'b1) got = 1'b1;
         if (!aDone && awready === 1'b1) begin
            aDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready === 1'b1) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic aDone, got;
      aDone = 1'b0;
      got   = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(posedge clk_sys);
         if (aDone && rvalid === 1'b1) got = 1'b1;
         if (!aDone && arready === 1'b1) begin
            aDone = 1'b1;
            arvalid <= 1'b0;
         end
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   // ****************************************
   // reference model and checks
   // ****************************************
   task automatic doWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0]  r;
      logic [31:0] g;
      logic        mapped;
      mapped = a inside {prc_pkg::PORT_RST_OFS, prc_pkg::PERIPH_RST_OFS, prc_pkg::CAPS_FOUR_OFS};
      axiWrite(a, d, s, r);
      check({30'h0, r}, mapped ? {30'h0, prc_pkg::RESP_OKAY} : {30'h0, prc_pkg::RESP_SLVERR}, "bresp");
      g = {24'h0, capFour} & prc_pkg::PORT_RST_MASK;
      if (s[0] && a == prc_pkg::PORT_RST_OFS) portExp = (portExp & ~g) | (d & g);
      g = prc_pkg::PERIPH_RST_MASK;
      if (s[0] && a == prc_pkg::PERIPH_RST_OFS) perExp = (perExp & ~g) | (d & g);
   endtask

   task automatic checkAll();
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(prc_pkg::PORT_RST_OFS, d, r);
      check(d, portExp, "port register");
      check({30'h0, r}, {30'h0, prc_pkg::RESP_OKAY}, "port rresp");
      axiRead(prc_pkg::PERIPH_RST_OFS, d, r);
      check(d, perExp, "periph register");
      axiRead(prc_pkg::CAPS_FOUR_OFS, d, r);
      check(d, {24'h0, capFour}, "capabilities");
      check({20'h0, resetOut}, {20'h0, portExp[7:0], perExp[4], perExp[2:0]}, "reset lines");
      axiRead(12'h04C, d, r);
      check({d[31:2], r}, {30'h0, prc_pkg::RESP_SLVERR}, "unmapped read");
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset = 1'b1;
      {awaddr, araddr, wdata, wstrb, capFour} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {errCount, checks, cycles} = '0;
      addrTab = '{prc_pkg::PORT_RST_OFS, prc_pkg::PERIPH_RST_OFS, prc_pkg::CAPS_FOUR_OFS, 12'h04C};
      portExp = prc_pkg::PORT_RST_RESET;
      perExp = prc_pkg::PERIPH_RST_RESET;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      capFour <= 8'hFF;
      repeat (3) @(posedge clk_sys);
      check({20'h0, resetOut}, 32'h0, "reset lines after reset");
      checkAll();
      $display("test reset values done");
      // all present, all ones, then absent units, then zeros under a partial gate and split strobes
      doWrite(prc_pkg::PORT_RST_OFS, 32'hFFFF_FFFF, 4'hF);
      doWrite(prc_pkg::PERIPH_RST_OFS, 32'hFFFF_FFFF, 4'hF);
      checkAll();
      capFour <= 8'h00;
      @(posedge clk_sys);
      doWrite(prc_pkg::PORT_RST_OFS, 32'h0000_0000, 4'hF);
      checkAll();
      capFour <= 8'hA5;
      @(posedge clk_sys);
      doWrite(prc_pkg::PORT_RST_OFS, 32'h0000_0000, 4'hE);
      doWrite(prc_pkg::PORT_RST_OFS, 32'h0000_0000, 4'h1);
      doWrite(prc_pkg::PERIPH_RST_OFS, 32'h0000_0000, 4'hF);
      doWrite(prc_pkg::CAPS_FOUR_OFS, 32'h0000_0000, 4'hF);
      checkAll();
      $display("test corner cases done");
      // read-modify-write of one port bit, reserved bits written back as read
      axiRead(prc_pkg::PORT_RST_OFS, rmwVal, rmwResp);
      check({30'h0, rmwResp}, {30'h0, prc_pkg::RESP_OKAY}, "read before modify");
      doWrite(prc_pkg::PORT_RST_OFS, rmwVal ^ 32'h0000_0004, 4'hF);
      checkAll();
      $display("test read-modify-write done");
      // seeded random traffic
      repeat (60) begin
         rndA = rnd();
         capFour <= rndA[7:0];
         @(posedge clk_sys);
         rndA = rnd();
         rndD = rnd();
         rndS = rnd();
         doWrite(addrTab[rndA[1:0]], rndD, rndS[3:0]);
         checkAll();
      end
      $display("test random traffic done");
      // mid-run reset with every bit set
      capFour <= 8'hFF;
      @(posedge clk_sys);
      doWrite(prc_pkg::PORT_RST_OFS, 32'hFFFF_FFFF, 4'hF);
      doWrite(prc_pkg::PERIPH_RST_OFS, 32'hFFFF_FFFF, 4'hF);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      portExp = prc_pkg::PORT_RST_RESET;
      perExp = prc_pkg::PERIPH_RST_RESET;
      repeat (3) @(posedge clk_sys);
      check({20'h0, resetOut}, 32'h0, "reset lines after second reset");
      checkAll();
      $display("test mid-run reset done");
      summarize();
   end
endmodule
